// ==== verilog/codec_pin_function_mux.sv ====
// Pin function multiplexer and general-purpose I/O for the codec
// How it works
// - Input pin enable bit 1: 0 leaves pin unused, 1 makes it an input.
// - In SPI mode the input pin is chip select; enable bit ignored.
// - Bits 7,6,5 give output levels of bidir one, two, output pin one.
// - Bits 3,2,1 report sampled levels of configured input pins.
// - Control clock source: 0 off, 1-3 bidir one, bidir two, input pin.
// - Second data input source: 0 off, 1-5 pins or data input.
// - Bit-clock select: 0 dedicated pin, 1 secondary port bit clock.
// - Frame-sync select: 0 dedicated pin, 1 secondary port frame sync.
// - Serial output pin function codes 0-4: off, in, GPO, IRQ, PDM clock.
// - Codes 5-13 route port data, clocks, muxed and daisy outputs.
// - Code 14 loops data input back; code 15 reserved.
// - Bit 3 sets serial output pin level under general-purpose output.
// - Drive field selects among six push, pull, weak and Hi-Z styles.
// - Bidir pin two function code 1 makes it an input.
`timescale 1ns/1ps
`include "pin_mux_cfg.svh"

module codec_pin_function_mux
    import pin_mux_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Control interface mode
    input wire logic spi_mode_i,
    output logic spi_cs_n_o,
    // Bidirectional pins
    input wire logic bidir_pin_one_i,
    output logic bidir_pin_one_o,
    output logic bidir_pin_one_oe_o,
    input wire logic bidir_pin_two_i,
    output logic bidir_pin_two_o,
    output logic bidir_pin_two_oe_o,
    // Dedicated input pin and output pin one
    input wire logic dedicated_input_pin_i,
    output logic output_pin_one_o,
    output logic output_pin_one_oe_o,
    // Serial output pin
    input wire logic serial_output_pin_i,
    output pin_drive_t serial_output_pin_o,
    // Primary port dedicated pins
    input wire logic data_in_pin_i,
    input wire logic bitclock_pin_i,
    input wire logic framesync_pin_i,
    // Core side
    input wire core_out_t core_out_i,
    output core_in_t core_in_o
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    localparam int NPIN = 7;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync_a_reg;
    logic [NPIN-1:0] sync_b_reg;
    logic [NPIN-1:0] sync_a_next;
    logic [NPIN-1:0] sync_b_next;

    assign pin_raw = {framesync_pin_i, bitclock_pin_i, data_in_pin_i,
                      serial_output_pin_i, dedicated_input_pin_i,
                      bidir_pin_two_i, bidir_pin_one_i};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_comb begin
                sync_a_next[gi] = pin_raw[gi];
                sync_b_next[gi] = sync_a_reg[gi];
            end
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    sync_a_reg[gi] <= 1'b0;
                    sync_b_reg[gi] <= 1'b0;
                end else begin
                    sync_a_reg[gi] <= sync_a_next[gi];
                    sync_b_reg[gi] <= sync_b_next[gi];
                end
            end
        end
    endgenerate

    logic s_one;
    logic s_two;
    logic s_inp;
    logic s_sop;
    logic s_din;
    logic s_bclk;
    logic s_fsync;
    assign {s_fsync, s_bclk, s_din, s_sop, s_inp, s_two, s_one} = sync_b_reg;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [7:0] bidir_func_reg;
    logic [7:0] out_one_func_reg;
    logic [7:0] input_cfg_reg;
    logic [7:0] value_reg;
    logic [7:0] route0_reg;
    logic [7:0] sop_cfg_reg;
    logic [7:0] route2_reg;
    logic [7:0] bidir_func_next;
    logic [7:0] out_one_func_next;
    logic [7:0] input_cfg_next;
    logic [7:0] value_next;
    logic [7:0] route0_next;
    logic [7:0] sop_cfg_next;
    logic [7:0] route2_next;

    // Read-only and reserved bits are masked out of writes to the input, value and routing registers
    always_comb begin
        bidir_func_next = bidir_func_reg;
        out_one_func_next = out_one_func_reg;
        input_cfg_next = input_cfg_reg;
        value_next = value_reg;
        route0_next = route0_reg;
        sop_cfg_next = sop_cfg_reg;
        route2_next = route2_reg;
        if (wr_i) begin
            case (addr_i)
                `OFS_BIDIR_FUNC: bidir_func_next = wdata_i;
                `OFS_OUT_ONE_FUNC: out_one_func_next = wdata_i;
                `OFS_INPUT_PIN_CONFIG:
                    input_cfg_next = wdata_i & `WMASK_INPUT_PIN_CONFIG;
                `OFS_PIN_VALUE_MONITOR:
                    value_next = wdata_i & `WMASK_PIN_VALUE;
                `OFS_ROUTING_ZERO:
                    route0_next = wdata_i & `WMASK_ROUTING_ZERO;
                `OFS_SERIAL_OUT_CONFIG: sop_cfg_next = wdata_i;
                `OFS_ROUTING_TWO:
                    route2_next = wdata_i & `WMASK_ROUTING_TWO;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bidir_func_reg <= `RST_BIDIR_FUNC;
            out_one_func_reg <= `RST_OUT_ONE_FUNC;
            input_cfg_reg <= `RST_INPUT_PIN_CONFIG;
            value_reg <= `RST_PIN_VALUE_MONITOR;
            route0_reg <= `RST_ROUTING_ZERO;
            sop_cfg_reg <= `RST_SERIAL_OUT_CONFIG;
            route2_reg <= `RST_ROUTING_TWO;
        end else begin
            bidir_func_reg <= bidir_func_next;
            out_one_func_reg <= out_one_func_next;
            input_cfg_reg <= input_cfg_next;
            value_reg <= value_next;
            route0_reg <= route0_next;
            sop_cfg_reg <= sop_cfg_next;
            route2_reg <= route2_next;
        end
    end

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    logic [3:0] one_func;
    logic [3:0] two_func;
    logic [3:0] out1_func;
    logic [3:0] sop_func;
    logic [2:0] sop_drive;
    logic [1:0] control_clock_source;
    logic [2:0] second_sel;
    logic one_is_in;
    logic two_is_in;
    logic inp_is_in;
    logic sop_is_in;
    assign one_func = bidir_func_reg[3:0];
    assign two_func = bidir_func_reg[7:4];
    assign out1_func = out_one_func_reg[7:4];
    assign sop_func = sop_cfg_reg[`FLD_SOP_FUNC_HI:`FLD_SOP_FUNC_LO];
    assign sop_drive = sop_cfg_reg[`FLD_SOP_DRIVE_HI:`FLD_SOP_DRIVE_LO];
    assign control_clock_source = route0_reg[`FLD_CCLK_HI:`FLD_CCLK_LO];
    assign second_sel = route0_reg[`FLD_SECOND_IN_HI:`FLD_SECOND_IN_LO];
    assign one_is_in = (one_func == `FN_INPUT);
    assign two_is_in = (two_func == `FN_INPUT);
    // Chip select mode takes the pin over whatever the enable says
    assign inp_is_in = input_cfg_reg[`BIT_INPUT_PIN_ENABLE] & ~spi_mode_i;
    assign sop_is_in = (sop_func == `FN_INPUT) | (sop_func == `FN_LOOPBACK);

    // ------------------------------------------------------------------
    // Serial output pin
    // ------------------------------------------------------------------
    logic sop_src;
    logic sop_active;
    always_comb begin
        sop_src = 1'b0;
        sop_active = 1'b1;
        case (sop_func)
            `FN_GP_OUT: sop_src = sop_cfg_reg[`BIT_SOP_LEVEL];
            `FN_IRQ: sop_src = core_out_i.irq;
            `FN_PDM_CLK: sop_src = core_out_i.pdm_clk;
            `FN_PRI_DOUT: sop_src = core_out_i.pri_dout;
            `FN_PRI_DOUT2: sop_src = core_out_i.pri_dout2;
            `FN_SEC_DOUT: sop_src = core_out_i.sec_dout;
            `FN_SEC_DOUT2: sop_src = core_out_i.sec_dout2;
            `FN_SEC_BCLK: sop_src = core_out_i.sec_bclk;
            `FN_SEC_FSYNC: sop_src = core_out_i.sec_fsync;
            `FN_CLK_OUT: sop_src = core_out_i.clk_out;
            `FN_BOTH_MUXED: sop_src = core_out_i.both_muxed;
            `FN_DAISY: sop_src = core_out_i.daisy_out;
            `FN_LOOPBACK: sop_src = s_din;
            // Disabled, input and the reserved code never drive
            default: sop_active = 1'b0;
        endcase
    end

    pin_drive_t sop_next;
    always_comb begin
        sop_next = '0;
        sop_next.level = sop_src;
        if (sop_active) begin
            case (sop_drive)
                `DRV_PUSH_PULL: sop_next.strong_oe = 1'b1;
                `DRV_LOW_WEAK_HIGH: begin
                    sop_next.strong_oe = ~sop_src;
                    sop_next.weak_oe = sop_src;
                end
                `DRV_LOW_ONLY: sop_next.strong_oe = ~sop_src;
                `DRV_WEAK_LOW_HIGH: begin
                    sop_next.strong_oe = sop_src;
                    sop_next.weak_oe = ~sop_src;
                end
                `DRV_HIGH_ONLY: sop_next.strong_oe = sop_src;
                // Hi-Z and the reserved codes float the pin
                default: sop_next.strong_oe = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Routing into the core
    // ------------------------------------------------------------------
    logic g_one;
    logic g_two;
    logic g_inp;
    logic g_sop;
    logic g_din;
    assign g_one = s_one & one_is_in;
    assign g_two = s_two & two_is_in;
    assign g_inp = s_inp & inp_is_in;
    assign g_sop = s_sop & sop_is_in;
    assign g_din = s_din & route2_reg[`BIT_DATA_IN_ENABLE];
    // Source code n picks bit n; off and reserved codes read 0
    logic [7:0] src_vec;
    assign src_vec = {2'b00, g_din, g_sop, g_inp, g_two, g_one, 1'b0};

    core_in_t core_in_next;
    always_comb begin
        core_in_next.control_clock = src_vec[{1'b0, control_clock_source}];
        core_in_next.pri_second_in = src_vec[second_sel];
        core_in_next.pri_data_in = g_din;
        core_in_next.pri_bitclock = route0_reg[`BIT_BCLK_SEL] ?
            core_out_i.sec_bclk : s_bclk;
        core_in_next.pri_framesync = route0_reg[`BIT_FSYNC_SEL] ?
            core_out_i.sec_fsync : s_fsync;
    end

    // ------------------------------------------------------------------
    // Pin outputs, chip select and read data
    // ------------------------------------------------------------------
    logic [2:0] mon;
    logic [7:0] rdata_next;
    assign mon = {g_one, g_two, g_inp};

    always_comb begin
        rdata_next = 8'h00;
        if (rd_i) begin
            case (addr_i)
                `OFS_BIDIR_FUNC: rdata_next = bidir_func_reg;
                `OFS_OUT_ONE_FUNC: rdata_next = out_one_func_reg;
                `OFS_INPUT_PIN_CONFIG: rdata_next = input_cfg_reg;
                `OFS_PIN_VALUE_MONITOR: begin
                    rdata_next = value_reg;
                    rdata_next[`BIT_BIDIR_ONE_MON] = mon[2];
                    rdata_next[`BIT_BIDIR_TWO_MON] = mon[1];
                    rdata_next[`BIT_INPUT_PIN_MON] = mon[0];
                end
                `OFS_ROUTING_ZERO: rdata_next = route0_reg;
                `OFS_SERIAL_OUT_CONFIG: rdata_next = sop_cfg_reg;
                `OFS_ROUTING_TWO: rdata_next = route2_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
            serial_output_pin_o <= '0;
            core_in_o <= '0;
            spi_cs_n_o <= 1'b1;
            bidir_pin_one_o <= 1'b0;
            bidir_pin_one_oe_o <= 1'b0;
            bidir_pin_two_o <= 1'b0;
            bidir_pin_two_oe_o <= 1'b0;
            output_pin_one_o <= 1'b0;
            output_pin_one_oe_o <= 1'b0;
        end else begin
            rdata_o <= rdata_next;
            serial_output_pin_o <= sop_next;
            core_in_o <= core_in_next;
            // Idle high outside chip select mode
            spi_cs_n_o <= spi_mode_i ? s_inp : 1'b1;
            bidir_pin_one_o <= value_reg[`BIT_BIDIR_ONE_OUT];
            bidir_pin_one_oe_o <= (one_func == `FN_GP_OUT);
            bidir_pin_two_o <= value_reg[`BIT_BIDIR_TWO_OUT];
            bidir_pin_two_oe_o <= (two_func == `FN_GP_OUT);
            output_pin_one_o <= value_reg[`BIT_OUT_ONE_OUT];
            output_pin_one_oe_o <= (out1_func == `FN_GP_OUT);
        end
    end

endmodule

// ==== verilog/pin_mux_cfg.svh ====
// Register offsets, field positions, reset values and function codes
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_BIDIR_FUNC 8'h0a
`define OFS_OUT_ONE_FUNC 8'h0b
`define OFS_INPUT_PIN_CONFIG 8'h0d
`define OFS_PIN_VALUE_MONITOR 8'h0e
`define OFS_ROUTING_ZERO 8'h0f
`define OFS_SERIAL_OUT_CONFIG 8'h10
`define OFS_ROUTING_TWO 8'h11

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_BIDIR_FUNC 8'h00
`define RST_OUT_ONE_FUNC 8'h00
`define RST_INPUT_PIN_CONFIG 8'h00
`define RST_PIN_VALUE_MONITOR 8'h00
`define RST_ROUTING_ZERO 8'h00
`define RST_SERIAL_OUT_CONFIG 8'h52
`define RST_ROUTING_TWO 8'h80

// ----------------------------------------------------------------------
// Writable bit masks
// ----------------------------------------------------------------------
`define WMASK_INPUT_PIN_CONFIG 8'h03
`define WMASK_PIN_VALUE 8'he0
`define WMASK_ROUTING_ZERO 8'h7f
`define WMASK_ROUTING_TWO 8'hfe

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_INPUT_PIN_ENABLE 1
`define BIT_BIDIR_ONE_OUT 7
`define BIT_BIDIR_TWO_OUT 6
`define BIT_OUT_ONE_OUT 5
`define BIT_BIDIR_ONE_MON 3
`define BIT_BIDIR_TWO_MON 2
`define BIT_INPUT_PIN_MON 1
`define FLD_CCLK_HI 6
`define FLD_CCLK_LO 5
`define FLD_SECOND_IN_HI 4
`define FLD_SECOND_IN_LO 2
`define BIT_BCLK_SEL 1
`define BIT_FSYNC_SEL 0
`define FLD_SOP_FUNC_HI 7
`define FLD_SOP_FUNC_LO 4
`define BIT_SOP_LEVEL 3
`define FLD_SOP_DRIVE_HI 2
`define FLD_SOP_DRIVE_LO 0
`define BIT_DATA_IN_ENABLE 7

// ----------------------------------------------------------------------
// Pin function codes
// ----------------------------------------------------------------------
`define FN_INPUT 4'h1
`define FN_GP_OUT 4'h2
`define FN_IRQ 4'h3
`define FN_PDM_CLK 4'h4
`define FN_PRI_DOUT 4'h5
`define FN_PRI_DOUT2 4'h6
`define FN_SEC_DOUT 4'h7
`define FN_SEC_DOUT2 4'h8
`define FN_SEC_BCLK 4'h9
`define FN_SEC_FSYNC 4'ha
`define FN_CLK_OUT 4'hb
`define FN_BOTH_MUXED 4'hc
`define FN_DAISY 4'hd
`define FN_LOOPBACK 4'he

// ----------------------------------------------------------------------
// Drive style codes
// ----------------------------------------------------------------------
`define DRV_PUSH_PULL 3'h1
`define DRV_LOW_WEAK_HIGH 3'h2
`define DRV_LOW_ONLY 3'h3
`define DRV_WEAK_LOW_HIGH 3'h4
`define DRV_HIGH_ONLY 3'h5
`endif

// ==== verilog/pin_mux_pkg.sv ====
// Types shared by the pin function multiplexer
package pin_mux_pkg;

    // Signals offered by the codec core for the serial output pin
    typedef struct packed {
        logic irq;
        logic pdm_clk;
        logic pri_dout;
        logic pri_dout2;
        logic sec_dout;
        logic sec_dout2;
        logic sec_bclk;
        logic sec_fsync;
        logic clk_out;
        logic both_muxed;
        logic daisy_out;
    } core_out_t;

    // Signals routed into the codec core
    typedef struct packed {
        logic control_clock;
        logic pri_second_in;
        logic pri_data_in;
        logic pri_bitclock;
        logic pri_framesync;
    } core_in_t;

    // One driven pin: level, strong enable, weak pull enable
    typedef struct packed {
        logic level;
        logic strong_oe;
        logic weak_oe;
    } pin_drive_t;

endpackage

// ==== dv/pin_drive_ref.svh ====
// Expected strong and weak enables of a pin for each drive style
function automatic logic [1:0] drv_oe(input logic [2:0] d, input logic l);
    case (d)
        `DRV_PUSH_PULL: return 2'b10;
        `DRV_LOW_WEAK_HIGH: return l ? 2'b01 : 2'b10;
        `DRV_LOW_ONLY: return l ? 2'b00 : 2'b10;
        `DRV_WEAK_LOW_HIGH: return l ? 2'b10 : 2'b01;
        `DRV_HIGH_ONLY: return l ? 2'b10 : 2'b00;
        default: return 2'b00;
    endcase
endfunction

// ==== dv/pin_mux_monitor.sv ====
// Concurrent checks on the pin function multiplexer ports
`timescale 1ns/1ps
`include "pin_mux_cfg.svh"

module pin_mux_monitor
    import pin_mux_pkg::*;
(
    // Clock, reset and register port
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    // Pins
    input wire logic spi_mode_i,
    input wire logic spi_cs_n_o,
    input wire logic bidir_pin_one_o,
    input wire logic bidir_pin_two_o,
    input wire logic output_pin_one_o,
    input wire logic dedicated_input_pin_i,
    input wire logic data_in_pin_i,
    input wire logic bitclock_pin_i,
    input wire logic framesync_pin_i,
    input wire pin_drive_t serial_output_pin_o,
    // Core side
    input wire core_out_t core_out_i,
    input wire core_in_t core_in_o
);
    logic [7:0] val, rz, sop, val_d, rz_d, sop_d;
    core_out_t co_d;
    logic [3:0] fn;
    logic [2:0] dv;
    logic [1:0] oe;

    `include "pin_drive_ref.svh"

    assign fn = sop_d[7:4];
    assign dv = sop_d[2:0];
    assign oe = {serial_output_pin_o.strong_oe, serial_output_pin_o.weak_oe};

    // Lags once more: pin outputs are registered
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            val <= `RST_PIN_VALUE_MONITOR;
            rz <= `RST_ROUTING_ZERO;
            sop <= `RST_SERIAL_OUT_CONFIG;
            val_d <= `RST_PIN_VALUE_MONITOR;
            rz_d <= `RST_ROUTING_ZERO;
            sop_d <= `RST_SERIAL_OUT_CONFIG;
            co_d <= '0;
        end else begin
            if (wr_i && addr_i == `OFS_PIN_VALUE_MONITOR)
                val <= wdata_i & `WMASK_PIN_VALUE;
            if (wr_i && addr_i == `OFS_ROUTING_ZERO)
                rz <= wdata_i & `WMASK_ROUTING_ZERO;
            if (wr_i && addr_i == `OFS_SERIAL_OUT_CONFIG)
                sop <= wdata_i;
            val_d <= val;
            rz_d <= rz;
            sop_d <= sop;
            co_d <= core_out_i;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_gpo_levels: assert property (
        1'b1 |-> {bidir_pin_one_o, bidir_pin_two_o,
            output_pin_one_o} == val_d[7:5])
        else $error("output pin levels wrong");
    a_sop_gpo: assert property (
        fn == `FN_GP_OUT && dv == `DRV_PUSH_PULL
            |-> serial_output_pin_o.level == sop_d[3])
        else $error("serial pin level wrong");
    a_sop_style: assert property (
        fn == `FN_GP_OUT |-> oe == drv_oe(dv, sop_d[3]))
        else $error("serial pin drive style wrong");
    a_sop_core: assert property (
        fn inside {[4'h3:4'hd]} && dv == `DRV_PUSH_PULL
            |-> serial_output_pin_o == {co_d[4'hd - fn], 2'b10})
        else $error("serial pin core route wrong");
    a_sop_loop: assert property (
        $past(nrst_i, 3) && fn == `FN_LOOPBACK && dv == `DRV_PUSH_PULL
            |-> serial_output_pin_o.level == $past(data_in_pin_i, 3))
        else $error("serial pin loopback wrong");
    a_sop_quiet: assert property (
        fn inside {4'h0, 4'h1, 4'hf} |-> oe == 2'b00)
        else $error("serial pin driven while off");
    a_bclk_pin: assert property (
        $past(nrst_i, 3) && !rz_d[1]
            |-> core_in_o.pri_bitclock == $past(bitclock_pin_i, 3))
        else $error("bit clock route wrong");
    a_fsync_pin: assert property (
        !rz_d[0] && $past(nrst_i, 3)
            |-> core_in_o.pri_framesync == $past(framesync_pin_i, 3))
        else $error("frame sync route wrong");
    a_cclk_off: assert property (
        rz_d[6:5] == 2'h0 |-> !core_in_o.control_clock)
        else $error("control clock not off");
    a_cs_follow: assert property (
        $past(nrst_i, 3) |-> spi_cs_n_o == ($past(spi_mode_i) ?
            $past(dedicated_input_pin_i, 3) : 1'b1))
        else $error("chip select wrong");
endmodule

bind codec_pin_function_mux pin_mux_monitor u_chk (.clk_i, .nrst_i, .addr_i,
    .wdata_i, .wr_i, .spi_mode_i, .spi_cs_n_o, .bidir_pin_one_o,
    .bidir_pin_two_o, .output_pin_one_o, .dedicated_input_pin_i,
    .data_in_pin_i, .bitclock_pin_i, .framesync_pin_i,
    .serial_output_pin_o, .core_out_i, .core_in_o);

// ==== dv/pin_board_model.sv ====
// Board side of the shared pins: resolves each wire from all drivers
`timescale 1ns/1ps

module pin_board_model
    import pin_mux_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Device drivers
    input wire logic one_drv_i,
    input wire logic one_oe_i,
    input wire logic two_drv_i,
    input wire logic two_oe_i,
    input wire pin_drive_t sop_i,
    // Board drivers, bit 0 pin one, bit 1 pin two, bit 2 serial pin
    input wire logic [2:0] ext_en_i,
    input wire logic [2:0] ext_lvl_i,
    // Resolved wires
    output logic one_o,
    output logic two_o,
    output logic sop_o
);
    logic tog = 1'b0;

    // A floating wire wanders, so a stale level is never trusted
    always @(posedge clk_i) tog <= ~tog;

    always_comb begin
        one_o = one_oe_i ? one_drv_i : (ext_en_i[0] ? ext_lvl_i[0] : tog);
        two_o = two_oe_i ? two_drv_i : (ext_en_i[1] ? ext_lvl_i[1] : tog);
        if (sop_i.strong_oe) sop_o = sop_i.level;
        else if (ext_en_i[2]) sop_o = ext_lvl_i[2];
        else if (sop_i.weak_oe) sop_o = sop_i.level;
        else sop_o = tog;
    end
endmodule

// ==== dv/tb_codec_pin_function_mux.sv ====
// Self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
`include "pin_mux_cfg.svh"

module tb_codec_pin_function_mux;
    import pin_mux_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic spi_mode_i = 1'b0;
    logic dedicated_input_pin_i = 1'b0;
    logic data_in_pin_i = 1'b0;
    logic bitclock_pin_i = 1'b0;
    logic framesync_pin_i = 1'b0;
    logic [2:0] ext_en = 3'h0;
    logic [2:0] ext_lvl = 3'h0;
    core_out_t core_out_i = '0;
    core_in_t core_in_o;
    pin_drive_t serial_output_pin_o;
    logic [7:0] rdata_o, e;
    logic [7:0] ofs [6] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h20};
    logic [7:0] rst [6] = '{8'h00, 8'h00, 8'h00, 8'h52, 8'h80, 8'h00};
    logic [4:0] pat;
    logic [5:0] gp;
    logic [2:0] sp;
    logic spi_cs_n_o, one_w, two_w, sop_w, lv;
    logic bidir_pin_one_o, bidir_pin_one_oe_o;
    logic bidir_pin_two_o, bidir_pin_two_oe_o;
    logic output_pin_one_o, output_pin_one_oe_o;
    int error_cnt = 0;
    int checked = 0;

    `include "pin_drive_ref.svh"

    assign gp = {bidir_pin_one_o, bidir_pin_one_oe_o, bidir_pin_two_o,
        bidir_pin_two_oe_o, output_pin_one_o, output_pin_one_oe_o};
    assign sp = serial_output_pin_o;

    initial forever #12.5 clk_i = ~clk_i;

    codec_pin_function_mux DUT (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .spi_mode_i, .spi_cs_n_o,
        .bidir_pin_one_i(one_w), .bidir_pin_one_o, .bidir_pin_one_oe_o,
        .bidir_pin_two_i(two_w), .bidir_pin_two_o, .bidir_pin_two_oe_o,
        .dedicated_input_pin_i, .output_pin_one_o, .output_pin_one_oe_o,
        .serial_output_pin_i(sop_w), .serial_output_pin_o, .data_in_pin_i,
        .bitclock_pin_i, .framesync_pin_i, .core_out_i, .core_in_o);

    pin_board_model board (.clk_i, .one_drv_i(bidir_pin_one_o),
        .one_oe_i(bidir_pin_one_oe_o), .two_drv_i(bidir_pin_two_o),
        .two_oe_i(bidir_pin_two_oe_o), .sop_i(serial_output_pin_o),
        .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .one_o(one_w),
        .two_o(two_w), .sop_o(sop_w));

    // ------------------------------------------------------------------
    // Bus access and reporting
    // ------------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] x, logic [7:0] s);
        checked++;
        if (s !== x) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, x, s);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk("rdata", x, rdata_o);
    endtask

    // Pins reach outputs and monitors through three flops
    task hold();
        repeat (4) @(posedge clk_i);
        #1;
    endtask

    task complete_run();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        complete_run();
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        foreach (ofs[i]) rd(ofs[i], rst[i]);
        wr(8'h0e, 8'hff);
        rd(8'h0e, 8'he0);
        wr(8'h0f, 8'h80);
        rd(8'h0f, 8'h00);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00);
        wr(8'h0a, 8'h22);
        wr(8'h0b, 8'h20);
        hold();
        chk("gpo pins", 8'h3f, 8'(gp));
        wr(8'h0e, 8'h40);
        hold();
        chk("gpo pins", 8'h1d, 8'(gp));
        wr(8'h0a, 8'h11);
        wr(8'h0d, 8'h02);
        ext_en <= 3'h3;
        ext_lvl <= 3'h1;
        dedicated_input_pin_i <= 1'b1;
        hold();
        rd(8'h0e, 8'h4a);
        ext_lvl <= 3'h2;
        dedicated_input_pin_i <= 1'b0;
        hold();
        rd(8'h0e, 8'h44);
        dedicated_input_pin_i <= 1'b1;
        wr(8'h0d, 8'h00);
        hold();
        rd(8'h0e, 8'h44);
        wr(8'h0d, 8'h02);
        spi_mode_i <= 1'b1;
        hold();
        rd(8'h0e, 8'h44);
        chk("chip select", 8'h01, 8'(spi_cs_n_o));
        dedicated_input_pin_i <= 1'b0;
        hold();
        chk("chip select", 8'h00, 8'(spi_cs_n_o));
        spi_mode_i <= 1'b0;
        wr(8'h10, 8'h10);
        ext_en <= 3'h7;
        for (int p = 0; p < 2; p++) begin
            pat = p ? 5'h0a : 5'h15;
            ext_lvl <= {pat[3], pat[1], pat[0]};
            dedicated_input_pin_i <= pat[2];
            data_in_pin_i <= pat[4];
            for (int k = 1; k < 6; k++) begin
                wr(8'h0f, {1'b0, k < 4 ? k[1:0] : 2'h0, k[2:0], 2'h0});
                hold();
                e = 8'({k < 4 && pat[k-1], pat[k-1], pat[4]});
                chk("routes", e, 8'(core_in_o[4:2]));
            end
        end
        wr(8'h0f, 8'h00);
        bitclock_pin_i <= 1'b1;
        core_out_i <= 11'h008;
        hold();
        chk("clock select", 8'h02, 8'(core_in_o[1:0]));
        wr(8'h0f, 8'h03);
        hold();
        chk("clock select", 8'h01, 8'(core_in_o[1:0]));
        ext_en <= 3'h3;
        for (int p = 0; p < 2; p++) begin
            core_out_i <= p ? 11'h555 : 11'h2aa;
            data_in_pin_i <= p[0];
            for (int f = 0; f < 15; f++) begin
                wr(8'h10, {f[3:0], p[0], 3'h1});
                hold();
                chk("sop oe", f < 2 ? 8'h00 : 8'h02, 8'(sp[1:0]));
                lv = (f == 2 || f == 14) ? p[0] : core_out_i[13 - f];
                if (f > 1) chk("sop level", 8'(lv), 8'(sp[2]));
            end
        end
        for (int d = 0; d < 6; d++) begin
            for (int l = 0; l < 2; l++) begin
                wr(8'h10, {4'h2, l[0], d[2:0]});
                hold();
                chk("drive", 8'(drv_oe(d[2:0], l[0])), 8'(sp[1:0]));
                chk("sop level", 8'(l), 8'(sp[2]));
            end
        end
        complete_run();
    end
endmodule
